// ---- src/csc_params.svh ----
// Purpose: named constants of the clock select and start-up controller
// Assumes: included by the top module and by the testbench
// Notes:   counts are in cycles of the clock they name
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH
// ****************************************************************
// register map
// ****************************************************************
`define CSC_ADDR_W          4
`define CSC_OFF_CTRL        4'h0
`define CSC_OFF_STATUS      4'h4
`define CSC_OFF_COUNT       4'h8
`define CSC_RESP_OKAY       2'h0
`define CSC_RESP_SLVERR     2'h2
// ****************************************************************
// fuse codes and shipped defaults (one = unprogrammed)
// ****************************************************************
`define CSC_SEL_EXT         4'h0
`define CSC_SEL_RSVD        4'h1
`define CSC_SEL_RC_CAL      4'h2
`define CSC_SEL_RC_128K     4'h3
`define CSC_SEL_LF_LO       4'h4
`define CSC_SEL_FS_LO       4'h6
`define CSC_SEL_LP_LO       4'h8
`define CSC_DEF_SEL         4'h2
`define CSC_DEF_SUT         2'h2
`define CSC_DEF_DIV8        1'h0
// ****************************************************************
// timing counts
// ****************************************************************
`define CSC_CNT_W           16
`define CSC_TOUT_NONE       16'h0000
`define CSC_TOUT_SHORT      16'h0200
`define CSC_TOUT_LONG       16'h2000
`define CSC_START_EXT       16'h0006
`define CSC_START_258       16'h0102
`define CSC_START_1K        16'h0400
`define CSC_START_16K       16'h4000
`define CSC_START_32K       16'h8000
`define CSC_RESET_EXTRA     16'h000E
`define CSC_DIV8_LAST       3'h7
`endif

// ---- src/csc_pkg.sv ----
// Purpose: types shared by the clock select and start-up controller
// Assumes: nothing
// Notes:   constants live in csc_params.svh
package csc_pkg;
    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        SLP_IDLE,
        SLP_ADC_NOISE,
        SLP_POWER_DOWN,
        SLP_POWER_SAVE
    } csc_sleep_type;

    typedef struct packed {
        logic cpu;
        logic io;
        logic flash;
        logic asy;
        logic adc;
    } csc_clk_en_type;

    typedef struct packed {
        logic [3:0] clock_source_select;
        logic [1:0] startup_time_select;
        logic       clock_divide_by_eight;
    } csc_fuse_type;
endpackage

// ---- src/csc_clock_ctrl.sv ----
// Purpose: clock source select, start-up reset sequencing and clock domain gating
// Assumes: oscillator and watchdog inputs are slow raw waveforms sampled on sys_clk_i
// Notes:   fuses are sampled only in the reset hold state, registers via AXI4-Lite
//
// Behaviour
// - source fuses decode to six clock sources; code 0001 is reserved
// - fuse bit one means unprogrammed, zero means programmed
// - shipped defaults: calibrated RC, divide by eight, start-up select 10
// - internal reset stays on for a time-out after other resets release
// - time-out counts watchdog cycles: 0, 512 or 8192 by fuses
// - counter on selected oscillator holds reset for configured cycles, then releases
// - reset wake uses time-out plus start-up; power-save/down uses start-up only
// - start-up count runs from 6 external-clock cycles to 32K low-frequency cycles
// - unused module clocks halt according to the selected sleep mode
// - stopping the core clock stops register file, status and stack activity
// - certain external interrupts are detected even with peripheral clock halted
// - two-wire address recognition wakes the device in every sleep mode
// - flash clock runs whenever the core clock runs
// - asynchronous timer clock keeps running in idle, ADC noise and power-save sleep for real-time counting
// - converter clock domain stays on in ADC noise sleep while core and peripheral clocks stop
// - low-power crystal: bit zero and start-up bits pick 258/1K/16K, plus 14
`timescale 1ns/1ps
`include "csc_params.svh"
module csc_clock_ctrl
    import csc_pkg::*;
(
    // clock, reset, enable
    input  wire logic                   sys_clk_i,
    input  wire logic                   rstn_i,
    input  wire logic                   ce_i,
    // asynchronous pins
    input  wire logic                   reset_sources_n_i,
    input  wire logic                   watchdog_osc_i,
    input  wire logic [5:0]             osc_i,
    input  wire csc_fuse_type           fuse_i,
    input  wire logic                   ext_irq_i,
    input  wire logic                   two_wire_serial_port_match_i,
    // start-up and domain outputs
    output logic                        internal_reset_o,
    output csc_clk_en_type              clk_en_o,
    output logic                        sys_tick_o,
    output logic                        wake_o,
    // AXI4-Lite slave
    input  wire logic [`CSC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`CSC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready
);
    // ****************************************************************
    // reset release and pin synchronisers
    // ****************************************************************
    localparam int SYNC_W = 17;

    typedef enum {
        ST_HOLD,
        ST_TIMEOUT,
        ST_START,
        ST_RUN,
        ST_SLEEP,
        ST_WAKE
    } csc_state_type;

    logic [1:0]        rst_sync_reg;
    logic              rst_n;
    logic [SYNC_W-1:0] async_vec;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic              wdt_prev_reg;
    logic [5:0]        osc_prev_reg;

    // two flops release the asynchronous reset
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    assign async_vec = {fuse_i, two_wire_serial_port_match_i, ext_irq_i, osc_i,
                        watchdog_osc_i, reset_sources_n_i};

    // every pin passes two flops before use
    generate
        for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
            always_ff @(posedge sys_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_reg[i] <= 1'b0;
                    sync2_reg[i] <= 1'b0;
                end else if (ce_i) begin
                    sync1_reg[i] <= async_vec[i];
                    sync2_reg[i] <= sync1_reg[i];
                end
            end
        end
    endgenerate

    logic         src_rst_n;
    logic         wdt_edge;
    logic [5:0]   osc_edge;
    logic         irq_s;
    logic         twi_s;
    csc_fuse_type fuse_s;

    assign src_rst_n = sync2_reg[0];
    assign irq_s     = sync2_reg[8];
    assign twi_s     = sync2_reg[9];
    assign fuse_s    = sync2_reg[16:10];
    assign wdt_edge  = sync2_reg[1] & ~wdt_prev_reg;
    assign osc_edge  = sync2_reg[7:2] & ~osc_prev_reg;

    // previous levels for rising-edge detection
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wdt_prev_reg <= 1'b0;
            osc_prev_reg <= 6'h00;
        end else if (ce_i) begin
            wdt_prev_reg <= sync2_reg[1];
            osc_prev_reg <= sync2_reg[7:2];
        end
    end

    // ****************************************************************
    // fuse decoding
    // ****************************************************************
    // source index: 0 low-power, 1 full-swing, 2 low-freq, 3 128k RC, 4 cal RC, 5 external
    function automatic logic [2:0] src_index(input logic [3:0] sel);
        if (sel >= `CSC_SEL_LP_LO)          src_index = 3'h0;
        else if (sel >= `CSC_SEL_FS_LO)     src_index = 3'h1;
        else if (sel >= `CSC_SEL_LF_LO)     src_index = 3'h2;
        else if (sel == `CSC_SEL_RC_128K)   src_index = 3'h3;
        else if (sel == `CSC_SEL_RC_CAL)    src_index = 3'h4;
        else                                src_index = 3'h5;
    endfunction

    function automatic logic is_crystal(input logic [3:0] sel);
        is_crystal = (sel >= `CSC_SEL_FS_LO);
    endfunction

    // time-out in watchdog cycles; zero is only safe with brown-out detection
    function automatic logic [`CSC_CNT_W-1:0] tout_cycles(input csc_fuse_type f);
        logic [2:0] code;
        code = {f.clock_source_select[0], f.startup_time_select};
        if (is_crystal(f.clock_source_select)) begin
            case (code)
                3'h0, 3'h3, 3'h6: tout_cycles = `CSC_TOUT_SHORT;
                3'h1, 3'h4, 3'h7: tout_cycles = `CSC_TOUT_LONG;
                default:          tout_cycles = `CSC_TOUT_NONE;
            endcase
        end else begin
            case (f.startup_time_select)
                2'h0:    tout_cycles = `CSC_TOUT_NONE;
                2'h1:    tout_cycles = `CSC_TOUT_SHORT;
                default: tout_cycles = `CSC_TOUT_LONG;
            endcase
        end
    endfunction

    // oscillator start-up count for the selected source
    function automatic logic [`CSC_CNT_W-1:0] start_cycles(input csc_fuse_type f);
        logic [2:0] code;
        code = {f.clock_source_select[0], f.startup_time_select};
        case (src_index(f.clock_source_select))
            3'h0, 3'h1: begin
                case (code)
                    3'h0, 3'h1: start_cycles = `CSC_START_258;
                    3'h2, 3'h3,
                    3'h4:       start_cycles = `CSC_START_1K;
                    default:    start_cycles = `CSC_START_16K;
                endcase
            end
            3'h2:    start_cycles = `CSC_START_32K;
            default: start_cycles = `CSC_START_EXT;
        endcase
    endfunction

    // clock domains left running in each sleep mode
    function automatic csc_clk_en_type sleep_gate(input csc_sleep_type m);
        csc_clk_en_type g;
        g = '0;
        case (m)
            SLP_IDLE: begin
                g.io  = 1'b1;
                g.asy = 1'b1;
                g.adc = 1'b1;
            end
            SLP_ADC_NOISE: begin
                g.asy = 1'b1;
                g.adc = 1'b1;
            end
            SLP_POWER_SAVE: g.asy = 1'b1;
            default:        g = '0;
        endcase
        sleep_gate = g;
    endfunction

    // ****************************************************************
    // fuse capture
    // ****************************************************************
    csc_state_type  state_reg;
    csc_fuse_type   fuse_reg;
    logic           fuse_ok;
    logic [2:0]     src_sel;
    logic           osc_tick;

    // fuses follow the pins only while reset is held, then stay frozen
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            fuse_reg <= '{`CSC_DEF_SEL, `CSC_DEF_SUT, `CSC_DEF_DIV8};
        end else if (ce_i && state_reg == ST_HOLD) begin
            fuse_reg <= fuse_s;
        end
    end

    assign fuse_ok  = (fuse_reg.clock_source_select != `CSC_SEL_RSVD);
    assign src_sel  = src_index(fuse_reg.clock_source_select);
    assign osc_tick = osc_edge[src_sel];

    // ****************************************************************
    // start-up sequencer
    // ****************************************************************
    logic [`CSC_CNT_W-1:0] cnt_reg;
    logic [1:0]            sleep_mode_reg;
    logic                  sleep_go;
    logic                  wake_evt;
    logic [`CSC_CNT_W-1:0] reset_start;

    assign wake_evt    = irq_s | twi_s;
    assign reset_start = start_cycles(fuse_reg)
                       + (is_crystal(fuse_reg.clock_source_select) ? `CSC_RESET_EXTRA : `CSC_TOUT_NONE);

    // reset hold, time-out, oscillator start-up, run and sleep
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_HOLD;
            cnt_reg   <= `CSC_TOUT_NONE;
        end else if (ce_i) begin
            if (!src_rst_n) begin
                state_reg <= ST_HOLD;
            end else begin
                case (state_reg)
                    ST_HOLD: begin
                        if (fuse_ok) begin
                            cnt_reg   <= tout_cycles(fuse_reg);
                            state_reg <= ST_TIMEOUT;
                        end
                    end
                    ST_TIMEOUT: begin
                        if (cnt_reg == `CSC_TOUT_NONE) begin
                            cnt_reg   <= reset_start;
                            state_reg <= ST_START;
                        end else if (wdt_edge) begin
                            cnt_reg <= cnt_reg - 1'b1;
                        end
                    end
                    ST_START, ST_WAKE: begin
                        if (cnt_reg == `CSC_TOUT_NONE) begin
                            state_reg <= ST_RUN;
                        end else if (osc_tick) begin
                            cnt_reg <= cnt_reg - 1'b1;
                        end
                    end
                    ST_RUN: begin
                        if (sleep_go) begin
                            state_reg <= ST_SLEEP;
                        end
                    end
                    ST_SLEEP: begin
                        if (wake_evt) begin
                            if (sleep_mode_reg[1]) begin
                                cnt_reg   <= start_cycles(fuse_reg);
                                state_reg <= ST_WAKE;
                            end else begin
                                state_reg <= ST_RUN;
                            end
                        end
                    end
                    default: state_reg <= ST_HOLD;
                endcase
            end
        end
    end

    // ****************************************************************
    // domain gating and system tick
    // ****************************************************************
    logic [2:0] div_reg;

    // internal reset and clock enables follow the sequencer
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            internal_reset_o <= 1'b1;
            clk_en_o         <= '0;
            wake_o           <= 1'b0;
        end else if (ce_i) begin
            internal_reset_o <= (state_reg == ST_HOLD) || (state_reg == ST_TIMEOUT)
                             || (state_reg == ST_START);
            wake_o           <= (state_reg == ST_SLEEP) && wake_evt;
            case (state_reg)
                ST_RUN:   clk_en_o <= '1;
                ST_SLEEP: clk_en_o <= sleep_gate(csc_sleep_type'(sleep_mode_reg));
                default:  clk_en_o <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
            endcase
        end
    end

    // system tick: every oscillator edge, or every eighth when the divider is programmed
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            div_reg    <= 3'h0;
            sys_tick_o <= 1'b0;
        end else if (ce_i) begin
            sys_tick_o <= 1'b0;
            if (osc_tick && state_reg == ST_RUN) begin
                div_reg <= div_reg + 1'b1;
                if (fuse_reg.clock_divide_by_eight) begin
                    sys_tick_o <= 1'b1;
                end else if (div_reg == `CSC_DIV8_LAST) begin
                    sys_tick_o <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    logic [`CSC_ADDR_W-1:0] awaddr_reg;
    logic [31:0]            wdata_reg;
    logic                   wbyte0_reg;
    logic                   do_write;

    function automatic logic [31:0] read_word(input logic [`CSC_ADDR_W-1:0] a,
                                               input logic [31:0] st,
                                               input logic [31:0] ct);
        case (a)
            `CSC_OFF_CTRL:   read_word = {30'h0, sleep_mode_reg};
            `CSC_OFF_STATUS: read_word = st;
            `CSC_OFF_COUNT:  read_word = ct;
            default:         read_word = 32'h0;
        endcase
    endfunction

    logic [31:0] status_word;
    assign status_word = {11'h0, clk_en_o, 5'(state_reg), 2'h0, internal_reset_o, fuse_ok, fuse_reg};

    assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign sleep_go = do_write && awaddr_reg == `CSC_OFF_CTRL && wbyte0_reg && wdata_reg[2];

    // address and data taken in either order, answer after both
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CSC_RESP_OKAY;
            awaddr_reg    <= '0;
            wdata_reg     <= 32'h0;
            wbyte0_reg    <= 1'b0;
        end else if (ce_i) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_reg    <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_reg    <= s_axi_wdata;
                wbyte0_reg   <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_reg == `CSC_OFF_CTRL) ? `CSC_RESP_OKAY : `CSC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // sleep mode field is writable from the control word
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sleep_mode_reg <= 2'h0;
        end else if (ce_i && do_write && awaddr_reg == `CSC_OFF_CTRL && wbyte0_reg) begin
            sleep_mode_reg <= wdata_reg[1:0];
        end
    end

    // read answers one cycle after the address is taken
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `CSC_RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid  <= 1'b0;
                    s_axi_arready <= 1'b1;
                end
            end else if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid  <= 1'b1;
                s_axi_arready <= 1'b0;
                s_axi_rdata   <= read_word(s_axi_araddr, status_word, {16'h0, cnt_reg});
                s_axi_rresp   <= (s_axi_araddr == `CSC_OFF_CTRL || s_axi_araddr == `CSC_OFF_STATUS
                                  || s_axi_araddr == `CSC_OFF_COUNT) ? `CSC_RESP_OKAY : `CSC_RESP_SLVERR;
            end else begin
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule

// ---- bench/csc_clock_ctrl_properties.sv ----
// Purpose: concurrent checks on the clock controller ports
// Assumes: ce_i is held high
// Notes:   bound into every csc_clock_ctrl instance
`timescale 1ns/1ps
module csc_clock_ctrl_properties
    import csc_pkg::*;
(
    // clock and reset
    input wire logic           sys_clk_i,
    input wire logic           rstn_i,
    // watched pins
    input wire logic           reset_sources_n_i,
    input wire csc_fuse_type   fuse_i,
    input wire logic           ext_irq_i,
    input wire logic           two_wire_serial_port_match_i,
    input wire logic           internal_reset_o,
    input wire csc_clk_en_type clk_en_o,
    input wire logic           wake_o,
    // response channels
    input wire logic           s_axi_bvalid,
    input wire logic           s_axi_bready,
    input wire logic [1:0]     s_axi_bresp,
    input wire logic           s_axi_rvalid,
    input wire logic           s_axi_rready,
    input wire logic [31:0]    s_axi_rdata
);
    // ****************
    // properties
    // ****************
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    // reset sequencing and domain relations
    rst_hold_a: assert property (!reset_sources_n_i [*5] |-> internal_reset_o)
        else $error("reset released early");
    rsvd_hold_a: assert property (internal_reset_o && fuse_i.clock_source_select == 4'h1 |=> internal_reset_o)
        else $error("reserved code ran");
    flash_cpu_a: assert property (clk_en_o.flash == clk_en_o.cpu)
        else $error("flash and core enables differ");
    core_hold_a: assert property (internal_reset_o |-> !clk_en_o.cpu && !clk_en_o.io)
        else $error("core runs in reset");
    asy_io_a: assert property (clk_en_o.io |-> clk_en_o.asy)
        else $error("timer stopped");
    wake_run_a: assert property (wake_o |-> !internal_reset_o ##1 !internal_reset_o)
        else $error("wake set reset");
    irq_wake_a: assert property ($rose(ext_irq_i) && !internal_reset_o && !clk_en_o.cpu |-> ##[1:60] wake_o)
        else $error("interrupt did not wake");
    addr_wake_a: assert property ($rose(two_wire_serial_port_match_i) && !internal_reset_o && !clk_en_o.cpu
        |-> ##[1:60] wake_o)
        else $error("address match did not wake");
    // response channels hold until taken
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp unstable");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata unstable");
endmodule
bind csc_clock_ctrl csc_clock_ctrl_properties chk_u (.*);

// ---- bench/csc_osc_model.sv ----
// Purpose: free-running oscillator sources facing the controller
// Assumes: each source is slower than half the system clock
// Notes:   phase is unrelated to sys_clk_i
`timescale 1ns/1ps
module csc_osc_model (
    // raw oscillator waveforms
    output logic [5:0] osc_o
);
    // ****************
    // sources
    // ****************
    // all sources toggle every 33 ns so the 2-flop sampler sees every edge
    initial osc_o = 6'h00;
    always #33 osc_o = ~osc_o;
endmodule

// ---- bench/csc_clock_ctrl_tb.sv ----
// Purpose: self-checking bench of the clock controller
// Assumes: watchdog edges driven here, oscillators by the model
// Notes:   rows boot each fuse setting, hand tests follow
`timescale 1ns/1ps
`include "csc_params.svh"
module csc_clock_ctrl_tb
    import csc_pkg::*;
;
    // ****************
    // signals
    // ****************
    typedef struct packed { csc_fuse_type f; logic [15:0] t; } csc_row_type;
    logic sys_clk_i = 0, rstn_i = 0, ce_i = 1, reset_sources_n_i = 0, watchdog_osc_i = 0;
    logic ext_irq_i = 0, two_wire_serial_port_match_i = 0, internal_reset_o, sys_tick_o, wake_o;
    logic [5:0] osc_i;
    csc_fuse_type fuse_i = 7'h7F;
    csc_clk_en_type clk_en_o;
    logic [`CSC_ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    int n_mismatch = 0, check_count = 0, n;
    // zero time-out rows assume an external supply monitor
    csc_row_type rows [7] = '{{7'h11, 16'h0}, {7'h13, 16'h200}, {7'h70, 16'h200}, {7'h35, 16'h0},
        {7'h01, 16'h0}, {7'h19, 16'h0}, {7'h14, 16'h2000}};
    logic [7:0] sl [4] = '{8'h8B, 8'hA3, 8'hC0, 8'hE2};
    always #10 sys_clk_i = ~sys_clk_i;
    csc_clock_ctrl dut_u (.*);
    csc_osc_model osc_u (.osc_o(osc_i));
    // ****************
    // tasks
    // ****************
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tmo(input int k, input int lim);
        if (k >= lim) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] r);
        @(posedge sys_clk_i);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, 4'hF};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk_i);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        tmo(n, 50);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge sys_clk_i);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk_i);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        {v, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        tmo(n, 50);
    endtask
    task automatic boot(input csc_fuse_type f);
        {rstn_i, reset_sources_n_i, fuse_i} <= {2'h0, f};
        repeat (16) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        reset_sources_n_i <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
    endtask
    task automatic wd(input int k);
        repeat (k) begin
            watchdog_osc_i <= 1'b1;
            repeat (2) @(posedge sys_clk_i);
            watchdog_osc_i <= 1'b0;
            repeat (2) @(posedge sys_clk_i);
        end
    endtask
    // ****************
    // sequence
    // ****************
    initial begin
        foreach (rows[i]) begin
            boot(rows[i].f);
            check(internal_reset_o, 1'b1);
            if (rows[i].t > 0) begin
                wd(rows[i].t - 1);
                rd(4'h4, d, rs);
                check(d[15:11], 5'h01);
            end
            wd(1);
            for (n = 0; n < 9000 && internal_reset_o !== 1'b0; n++) @(posedge sys_clk_i);
            tmo(n, 9000);
            rd(4'h4, d, rs);
            check({d[20:11], d[8:0]}, {5'h1F, 5'h03, 1'b0, 1'b1, rows[i].f});
            n = 0;
            repeat (264) @(posedge sys_clk_i) n += sys_tick_o;
            check(n, rows[i].f[0] ? 7'h50 : 7'h0A);
            $display("row %0d done", i);
        end
        // sleep modes and wakes
        foreach (sl[i]) begin
            wr(4'h0, {29'h0, sl[i][7:5]}, rs);
            repeat (4) @(posedge sys_clk_i);
            check(clk_en_o, sl[i][4:0]);
            {two_wire_serial_port_match_i, ext_irq_i} <= i[0] ? 2'h2 : 2'h1;
            for (n = 0; n < 200 && clk_en_o.cpu !== 1'b1; n++) @(posedge sys_clk_i);
            tmo(n, 200);
            {two_wire_serial_port_match_i, ext_irq_i} <= 2'h0;
            check({internal_reset_o, clk_en_o}, 6'h1F);
            $display("sleep %0d done", i);
        end
        reset_sources_n_i <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        check(internal_reset_o, 1'b1);
        rd(4'hC, d, rs);
        check({rs, d}, {2'h2, 32'h0});
        wr(4'h4, 32'h0, rs);
        check(rs, 2'h2);
        // reserved code holds
        boot(7'h0B);
        wd(20);
        rd(4'h4, d, rs);
        check({internal_reset_o, d[15:11], d[7]}, 7'h40);
        $display("hand tests done");
        complete_run();
    end
endmodule
